// ==== hw/snf_front_end.sv ====
// Serial interface front end of a serial NAND flash device
`timescale 1ns/1ns
`include "snf_regs.svh"
module snf_front_end (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  output logic strobe_out,
  input wire snf_pkg::snf_lane_e lane_in,
  input wire logic dtr_in,
  input wire logic out_phase_in,
  input wire logic quad_enable_bit_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic mode3_out,
  output logic idle_out,
  output logic held_out,
  output logic iface_reset_out,
  input wire logic protect_bits_lock_in,
  input wire logic prot_wr_in,
  input wire logic [4:0] prot_wr_data_in,
  output logic [4:0] prot_bits_out,
  output logic prot_reject_out,
  input wire logic ecc_wr_in,
  input wire logic ecc_wr_val_in,
  output logic ecc_enabled_out,
  input wire logic [11:0] column_address_in,
  input wire logic [16:0] row_address_in,
  output logic col_valid_out,
  output logic spare_area_out,
  output logic prog_allowed_out,
  output logic [5:0] page_out,
  output logic [10:0] block_out
);
  import snf_pkg::*;

  // ----------------------------------------------------------------------
  // State and combinational helpers
  // ----------------------------------------------------------------------
  snf_state_s q;
  snf_state_s d;
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_pop;
  logic buf_ready;
  logic cs_high;
  logic sclk_lvl;
  logic hold_pin;
  logic wp_pin;
  logic hold_fn;
  logic run;
  logic rise;
  logic fall;
  logic dtr_ok;
  snf_lane_e lane;
  logic [3:0] lane_bits;
  logic [3:0] rx_next_cnt;
  logic [7:0] rx_next_sh;
  logic shift_ev;
  logic [7:0] tx_word;
  logic [3:0] tx_left;
  logic [3:0] oe_mask;

  // ----------------------------------------------------------------------
  // Output byte buffer
  // ----------------------------------------------------------------------
  snf_pair_buf u_buf (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .in_valid_in(tx_valid_in),
    .in_data_in(tx_data_in),
    .in_ready_out(buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_pop)
  );

  // ----------------------------------------------------------------------
  // Pin views and edge detection
  // ----------------------------------------------------------------------
  always_comb begin
    cs_high = q.sync[`SNF_PIN_CS];
    sclk_lvl = q.sync[`SNF_PIN_SCLK];
    hold_pin = q.sync[`SNF_PIN_HOLD];
    wp_pin = q.sync[`SNF_PIN_WP];
    hold_fn = ~quad_enable_bit_in;
    rise = sclk_lvl & ~q.sclk_prev;
    fall = ~sclk_lvl & q.sclk_prev;
    // Clock and data lines are ignored unless running with select low
    run = (q.hold_st == SNF_RUN) & ~cs_high;
    dtr_ok = dtr_in & quad_enable_bit_in;
    // Quad lanes need line 3 free of hold, so fall back to single
    if ((lane_in == SNF_X4) && !quad_enable_bit_in) begin
      lane = SNF_X1;
    end else begin
      lane = lane_in;
    end
    lane_bits = {1'b0, lane};
  end

  // ----------------------------------------------------------------------
  // Input shifter helpers
  // ----------------------------------------------------------------------
  always_comb begin
    rx_next_cnt = q.rx_cnt + lane_bits;
    case (lane)
      SNF_X1: begin
        rx_next_sh = {q.rx_sh[6:0], io_in_s(0)};
      end
      SNF_X2: begin
        rx_next_sh = {q.rx_sh[5:0], q.sync[1:0]};
      end
      SNF_X4: begin
        rx_next_sh = {q.rx_sh[3:0], q.sync[3:0]};
      end
      default: begin
        rx_next_sh = q.rx_sh;
      end
    endcase
  end

  function automatic logic io_in_s(input int idx);
    io_in_s = q.sync[idx];
  endfunction

  // ----------------------------------------------------------------------
  // Output shifter helpers
  // ----------------------------------------------------------------------
  always_comb begin
    // Falling edge always; rising edge too at double rate
    shift_ev = run & out_phase_in & (fall | (rise & dtr_ok));
    buf_pop = shift_ev & (q.tx_cnt == 4'h0) & buf_valid;
    if (q.tx_cnt == 4'h0) begin
      // Underrun sends zeros rather than stalling the host clock
      tx_word = buf_valid ? buf_data : 8'h00;
      tx_left = `SNF_BYTE_BITS;
    end else begin
      tx_word = q.tx_sh;
      tx_left = q.tx_cnt;
    end
    case (lane)
      SNF_X1: begin
        oe_mask = 4'h2;
      end
      SNF_X2: begin
        oe_mask = 4'h3;
      end
      SNF_X4: begin
        oe_mask = 4'hf;
      end
      default: begin
        oe_mask = 4'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.meta = {cs_n_in, sclk_in, io_in};
    d.sync = q.meta;
    d.sclk_prev = sclk_lvl;
    d.cs_prev = cs_high;
    d.rx_valid = 1'b0;
    d.iface_rst = 1'b0;
    d.prot_rej = 1'b0;

    // Mode follows the parked clock level when select falls
    if (!cs_high && q.cs_prev) begin
      d.mode3 = sclk_lvl;
    end

    // Hold machine
    case (q.hold_st)
      SNF_RUN: begin
        if (!cs_high && hold_fn && !hold_pin && !sclk_lvl) begin
          d.hold_st = SNF_HELD;
        end
      end
      SNF_HELD: begin
        if (cs_high) begin
          d.hold_st = SNF_LOCK;
          d.iface_rst = 1'b1;
        end else if ((hold_pin || !hold_fn) && !sclk_lvl) begin
          d.hold_st = SNF_RUN;
        end
      end
      SNF_LOCK: begin
        // Select low with hold still low is not a restart
        if (cs_high && (hold_pin || !hold_fn)) begin
          d.hold_st = SNF_RUN;
        end
      end
      default: begin
        d.hold_st = SNF_RUN;
      end
    endcase
    d.held = (d.hold_st != SNF_RUN);

    // Input bytes
    if (run && rise && !out_phase_in) begin
      d.rx_sh = rx_next_sh;
      if (rx_next_cnt >= `SNF_BYTE_BITS) begin
        d.rx_cnt = 4'h0;
        d.rx_data = rx_next_sh;
        d.rx_valid = 1'b1;
      end else begin
        d.rx_cnt = rx_next_cnt;
      end
    end

    // Output data; counts kept while held
    if (shift_ev) begin
      case (lane)
        SNF_X1: begin
          d.io_out = {2'h0, tx_word[7], 1'b0};
        end
        SNF_X2: begin
          d.io_out = {2'h0, tx_word[7:6]};
        end
        default: begin
          d.io_out = tx_word[7:4];
        end
      endcase
      d.tx_sh = tx_word << lane_bits;
      d.tx_cnt = tx_left - lane_bits;
      d.strobe = dtr_ok ? ~q.strobe : 1'b0;
    end
    if (run && out_phase_in) begin
      d.io_oe = oe_mask;
    end else begin
      d.io_oe = 4'h0;
    end
    if (!out_phase_in || !dtr_ok) begin
      d.strobe = 1'b0;
    end

    // Select high or hold reset drops the transfer in progress
    if (cs_high) begin
      d.rx_cnt = 4'h0;
      d.tx_cnt = 4'h0;
      d.io_oe = 4'h0;
      d.strobe = 1'b0;
    end

    // Idle when deselected with no clock activity
    d.idle = cs_high & ~rise & ~fall;

    // Block protect bits
    // Register writes go on whatever the hold state
    if (prot_wr_in) begin
      if (protect_bits_lock_in && !wp_pin && !quad_enable_bit_in) begin
        d.prot_rej = 1'b1;
      end else begin
        d.prot = prot_wr_data_in;
      end
    end

    // Error correction setting
    if (ecc_wr_in) begin
      d.ecc_en = ecc_wr_val_in;
    end

    // Address checks
    d.col_valid = (column_address_in <= `SNF_COL_LAST);
    d.spare = d.col_valid & (column_address_in >= `SNF_SPARE_BASE);
    d.prog_ok = d.col_valid &
      (~d.spare | ~q.ecc_en |
       (column_address_in <= `SNF_SPARE_PROG_LAST));
    d.page = row_address_in[`SNF_PAGE_MSB:`SNF_PAGE_LSB];
    d.blk = row_address_in[`SNF_BLOCK_MSB:`SNF_BLOCK_LSB];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      // Clock pin view resets low like its edge history, so no false edge
      q.meta <= 6'h20;
      q.sync <= 6'h20;
      q.cs_prev <= 1'b1;
      q.hold_st <= SNF_RUN;
      q.idle <= 1'b1;
      q.prot <= `SNF_PROT_RST;
      q.ecc_en <= `SNF_ECC_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign io_out = q.io_out;
  assign io_oe_out = q.io_oe;
  assign strobe_out = q.strobe;
  assign rx_data_out = q.rx_data;
  assign rx_valid_out = q.rx_valid;
  assign tx_ready_out = buf_ready;
  assign mode3_out = q.mode3;
  assign idle_out = q.idle;
  assign held_out = q.held;
  assign iface_reset_out = q.iface_rst;
  assign prot_bits_out = q.prot;
  assign prot_reject_out = q.prot_rej;
  assign ecc_enabled_out = q.ecc_en;
  assign col_valid_out = q.col_valid;
  assign spare_area_out = q.spare;
  assign prog_allowed_out = q.prog_ok;
  assign page_out = q.page;
  assign block_out = q.blk;

endmodule // snf_front_end

// ==== hw/snf_pair_buf.sv ====
// Two-entry buffer between the user byte source and the output shifter
`timescale 1ns/1ns
module snf_pair_buf (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in
);
  import snf_pkg::*;

  snf_buf_s q;
  snf_buf_s d;
  logic push;
  logic pop;
  logic wr;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    push = in_valid_in & ~q.full;
    pop = out_ready_in & (q.cnt != 2'h0);
    wr = q.rd ^ q.cnt[0];
    if (push) begin
      d.mem[wr] = in_data_in;
    end
    if (pop) begin
      d.rd = ~q.rd;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    // Registered full keeps ready free of the drain side's logic
    d.full = (d.cnt == 2'h2);
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_out = ~q.full;
  assign out_valid_out = (q.cnt != 2'h0);
  assign out_data_out = q.mem[q.rd];

endmodule // snf_pair_buf

// ==== include/snf_pkg.sv ====
// Types shared by the serial NAND front end
package snf_pkg;

  // ----------------------------------------------------------------------
  // Lane width; the one-hot code equals the bits moved per edge
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SNF_X1 = 3'h1,
    SNF_X2 = 3'h2,
    SNF_X4 = 3'h4
  } snf_lane_e;

  // ----------------------------------------------------------------------
  // Hold state machine
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SNF_RUN = 3'h1,
    SNF_HELD = 3'h2,
    SNF_LOCK = 3'h4
  } snf_hold_e;

  // ----------------------------------------------------------------------
  // Complete state of the front end
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic sclk_prev;
    logic cs_prev;
    snf_hold_e hold_st;
    logic mode3;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic strobe;
    logic held;
    logic idle;
    logic iface_rst;
    logic [4:0] prot;
    logic prot_rej;
    logic ecc_en;
    logic col_valid;
    logic spare;
    logic prog_ok;
    logic [5:0] page;
    logic [10:0] blk;
  } snf_state_s;

  // ----------------------------------------------------------------------
  // Two-entry buffer state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd;
    logic [1:0] cnt;
    logic full;
  } snf_buf_s;

endpackage

// ==== include/snf_regs.svh ====
// Constant definitions for the serial NAND front end
`ifndef SNF_REGS_SVH
`define SNF_REGS_SVH

// ----------------------------------------------------------------------
// Column address map
// ----------------------------------------------------------------------
`define SNF_COL_W 12
`define SNF_COL_LAST 12'h87f
`define SNF_SPARE_BASE 12'h800
`define SNF_SPARE_PROG_LAST 12'h83f

// ----------------------------------------------------------------------
// Row address fields
// ----------------------------------------------------------------------
`define SNF_ROW_W 17
`define SNF_PAGE_MSB 5
`define SNF_PAGE_LSB 0
`define SNF_BLOCK_MSB 16
`define SNF_BLOCK_LSB 6

// ----------------------------------------------------------------------
// Reset values, protect width and bits per byte
// ----------------------------------------------------------------------
`define SNF_PROT_W 5
`define SNF_PROT_RST 5'h00
`define SNF_ECC_RST 1'h1
`define SNF_BYTE_BITS 4'h8

// ----------------------------------------------------------------------
// Pin sample positions in the synchroniser vector
// ----------------------------------------------------------------------
`define SNF_PIN_HOLD 3
`define SNF_PIN_WP 2
`define SNF_PIN_SCLK 4
`define SNF_PIN_CS 5

`endif

// ==== sim/snf_front_end_assertions.sv ====
// Port checker for the serial NAND front end
`timescale 1ns/1ns
module snf_front_end_checker (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_oe_out,
  input wire logic strobe_out,
  input wire logic quad_enable_bit_in,
  input wire logic idle_out,
  input wire logic held_out,
  input wire logic iface_reset_out,
  input wire logic protect_bits_lock_in,
  input wire logic prot_wr_in,
  input wire logic [4:0] prot_wr_data_in,
  input wire logic [4:0] prot_bits_out,
  input wire logic prot_reject_out,
  input wire logic ecc_wr_in,
  input wire logic ecc_wr_val_in,
  input wire logic ecc_enabled_out,
  input wire logic [11:0] column_address_in,
  input wire logic [16:0] row_address_in,
  input wire logic col_valid_out,
  input wire logic prog_allowed_out,
  input wire logic [5:0] page_out,
  input wire logic [10:0] block_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // ------
  // Pin history; the protect pin passes a synchroniser first
  // ------
  logic [2:0] wp_q;
  logic wp_lock;
  logic wp_steady;
  assign wp_lock = protect_bits_lock_in && !io_in[2] && !quad_enable_bit_in;
  assign wp_steady = (wp_q == {3{io_in[2]}});
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q <= 3'h0;
    end else begin
      wp_q <= {wp_q[1:0], io_in[2]};
    end
  end
  a_prot_refused: assert property (prot_wr_in && wp_steady && wp_lock |=>
    prot_reject_out && $stable(prot_bits_out)) else $error("protect kept");
  a_prot_taken: assert property (prot_wr_in && wp_steady && !wp_lock |=>
    !prot_reject_out && prot_bits_out == $past(prot_wr_data_in))
    else $error("protect write lost");
  a_reject_cause: assert property (prot_reject_out |-> $past(prot_wr_in))
    else $error("reject without write");
  a_ecc_write: assert property (ecc_wr_in |=>
    ecc_enabled_out == $past(ecc_wr_val_in)) else $error("ecc write lost");
  a_col_bound: assert property (1'b1 |=>
    col_valid_out == ($past(column_address_in) <= 12'h87f))
    else $error("column bound wrong");
  a_spare_prog: assert property (1'b1 |=> prog_allowed_out ==
    ($past(column_address_in) <= ($past(ecc_enabled_out) ? 12'h83f : 12'h87f)))
    else $error("spare program gate wrong");
  a_row_split: assert property (1'b1 |=> page_out ==
    $past(row_address_in[5:0]) && block_out == $past(row_address_in[16:6]))
    else $error("row split wrong");
  a_held_float: assert property (held_out && $past(held_out) |->
    io_oe_out == 4'h0) else $error("driving while held");
  a_quad_no_hold: assert property (quad_enable_bit_in [*4] |->
    !$rose(held_out)) else $error("hold with quad enable");
  a_reset_pulse: assert property (iface_reset_out |->
    $past(held_out) ##1 !iface_reset_out) else $error("bad interface reset");
  a_idle_park: assert property ((cs_n_in && $stable(sclk_in)) [*8] |->
    idle_out) else $error("not idle");
  a_strobe_gate: assert property (!quad_enable_bit_in [*4] |->
    $stable(strobe_out)) else $error("strobe without quad enable");
  c_reject: cover property (prot_reject_out);
  c_iface_reset: cover property (iface_reset_out);
  c_hold_exit: cover property (held_out ##1 !held_out);
  c_strobe: cover property ($changed(strobe_out));
endmodule // snf_front_end_checker
bind snf_front_end snf_front_end_checker chk (.*);

// ==== sim/snf_front_end_tb_top.sv ====
// Self-checking bench for the serial NAND front end
`timescale 1ns/1ns
module snf_front_end_tb_top;
  import snf_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic dtr_in = 1'b0;
  logic out_phase_in = 1'b0;
  logic quad_enable_bit_in = 1'b0;
  logic tx_valid_in = 1'b0;
  logic protect_bits_lock_in = 1'b0;
  logic prot_wr_in = 1'b0;
  logic ecc_wr_in = 1'b0;
  logic ecc_wr_val_in = 1'b1;
  logic [7:0] tx_data_in = 8'h00;
  logic [4:0] prot_wr_data_in = 5'h00;
  logic [11:0] column_address_in = 12'h000;
  logic [16:0] row_address_in = 17'h00000;
  snf_lane_e lane_in = SNF_X1;
  logic sclk_in, cs_n_in, strobe_out, rx_valid_out, tx_ready_out, mode3_out;
  logic idle_out, held_out, iface_reset_out, prot_reject_out, ecc_enabled_out;
  logic col_valid_out, spare_area_out, prog_allowed_out, str_q;
  logic [3:0] io_in, io_out, io_oe_out, hdrv;
  logic [7:0] rx_data_out, rx_last, r;
  logic [4:0] prot_bits_out;
  logic [5:0] page_out;
  logic [10:0] block_out;
  int n_errors = 0;
  int tests_run = 0;
  int n_tog = 0;
  int n_rst = 0;
  always #4 mclk_in = ~mclk_in;
  // Released line 1 shows the inverse of its last driven value
  assign io_in = (io_oe_out & io_out) |
    (~io_oe_out & {hdrv[3:2], ~io_out[1], hdrv[0]});
  snf_host_model host (.mclk_in, .io_in, .sclk_out(sclk_in),
    .cs_n_out(cs_n_in), .io_drv_out(hdrv));
  snf_front_end uut (.mclk_in, .rstn_in, .sclk_in, .cs_n_in, .io_in, .io_out,
    .io_oe_out, .strobe_out, .lane_in, .dtr_in, .out_phase_in,
    .quad_enable_bit_in, .rx_data_out, .rx_valid_out, .tx_valid_in,
    .tx_data_in, .tx_ready_out, .mode3_out, .idle_out, .held_out,
    .iface_reset_out, .protect_bits_lock_in, .prot_wr_in, .prot_wr_data_in,
    .prot_bits_out, .prot_reject_out, .ecc_wr_in, .ecc_wr_val_in,
    .ecc_enabled_out, .column_address_in, .row_address_in, .col_valid_out,
    .spare_area_out, .prog_allowed_out, .page_out, .block_out);
  always @(posedge mclk_in) begin
    str_q <= strobe_out;
    if (strobe_out !== str_q) n_tog++;
    if (rx_valid_out === 1'b1) rx_last <= rx_data_out;
    if (iface_reset_out === 1'b1) n_rst++;
  end
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_held(input logic v);
    for (int k = 0; k < 20; k++) begin
      @(negedge mclk_in);
      if (held_out === v) return;
    end
    chk(held_out, v);
    close_out();
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    @(negedge mclk_in);
    chk({idle_out, held_out, ecc_enabled_out, tx_ready_out, prot_bits_out},
      16'h0160);
  endtask
  task automatic t_mode();
    for (int m = 0; m < 2; m++) begin
      host.sel(m[0]);
      host.xfer(m ? 8'hc3 : 8'h3c, 8, r);
      chk(mode3_out, m[0]);
      host.desel();
      chk(rx_last, m ? 8'hc3 : 8'h3c);
    end
  endtask
  task automatic t_prot();
    logic [11:0] tab = 12'b100_110_000_101;
    logic [2:0] c;
    logic [4:0] e;
    e = 5'h00;
    for (int i = 0; i < 4; i++) begin
      c = tab[11-3*i -: 3];
      @(posedge mclk_in);
      protect_bits_lock_in <= c[2];
      quad_enable_bit_in <= c[0];
      host.line(2, c[1]);
      repeat (4) @(posedge mclk_in);
      prot_wr_in <= 1'b1;
      prot_wr_data_in <= 5'h15 + 5'(i);
      @(posedge mclk_in);
      prot_wr_in <= 1'b0;
      @(negedge mclk_in);
      if (c != 3'b100) e = 5'h15 + 5'(i);
      chk(prot_reject_out, c == 3'b100);
      chk(prot_bits_out, e);
    end
    @(posedge mclk_in);
    host.line(2, 1'b1);
    quad_enable_bit_in <= 1'b0;
  endtask
  task automatic t_addr();
    logic [11:0] cl [8] = '{12'h000, 12'h7ff, 12'h800, 12'h83f, 12'h840,
      12'h87f, 12'h880, 12'hfff};
    logic v;
    for (int e = 1; e >= 0; e--) begin
      @(posedge mclk_in);
      ecc_wr_in <= 1'b1;
      ecc_wr_val_in <= e[0];
      @(posedge mclk_in);
      ecc_wr_in <= 1'b0;
      for (int j = 0; j < 8; j++) begin
        column_address_in <= cl[j];
        row_address_in <= {cl[j][10:0], 6'(j * 9)};
        @(posedge mclk_in);
        @(negedge mclk_in);
        v = cl[j] <= 12'h87f;
        chk(ecc_enabled_out, e[0]);
        chk({col_valid_out, spare_area_out}, {v, v && cl[j] >= 12'h800});
        chk(prog_allowed_out, v && !(e && cl[j] > 12'h83f));
        chk({page_out, block_out}, {6'(j * 9), cl[j][10:0]});
        @(posedge mclk_in);
      end
    end
  endtask
  task automatic t_hold();
    host.sel(1'b0);
    host.xfer(8'h96, 4, r);
    host.line(3, 1'b0);
    wait_held(1'b1);
    // Output phase while held, so a live driver would show
    @(posedge mclk_in);
    out_phase_in <= 1'b1;
    host.xfer(8'hff, 4, r);
    chk(io_oe_out, 4'h0);
    out_phase_in <= 1'b0;
    host.line(3, 1'b1);
    wait_held(1'b0);
    host.xfer(8'h60, 4, r);
    host.desel();
    chk(rx_last, 8'h96);
  endtask
  task automatic t_hold_reset();
    int n0;
    host.sel(1'b0);
    host.xfer(8'h5a, 3, r);
    host.line(3, 1'b0);
    wait_held(1'b1);
    n0 = n_rst;
    host.desel();
    chk(16'(n_rst - n0), 16'h0001);
    host.sel(1'b0);
    host.xfer(8'h5a, 8, r);
    host.desel();
    chk(rx_last, 8'h5a);
  endtask
  task automatic t_buf();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_in);
      tx_valid_in <= 1'b1;
      tx_data_in <= i ? 8'h3c : 8'ha5;
      @(posedge mclk_in);
      tx_valid_in <= 1'b0;
    end
    repeat (2) @(negedge mclk_in);
    chk(tx_ready_out, 1'b0);
    @(posedge mclk_in);
    out_phase_in <= 1'b1;
    host.sel(1'b1);
    host.xfer(8'h00, 8, r);
    chk(r, 8'ha5);
    host.xfer(8'h00, 8, r);
    chk(r, 8'h3c);
    host.desel();
    chk(tx_ready_out, 1'b1);
  endtask
  task automatic t_lanes();
    logic [15:0] oe_tab = 16'h23f2;
    int t;
    host.sel(1'b1);
    for (int i = 0; i < 4; i++) begin
      lane_in <= (i == 0) ? SNF_X1 : (i == 1) ? SNF_X2 : SNF_X4;
      dtr_in <= i > 1;
      quad_enable_bit_in <= i < 3;
      repeat (5) @(posedge mclk_in);
      t = n_tog;
      host.xfer(8'h00, 1, r);
      chk(io_oe_out, oe_tab[15-4*i -: 4]);
      chk(16'(n_tog - t), (i == 2) ? 16'h2 : 16'h0);
    end
    host.desel();
    out_phase_in <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    t_reset();
    t_mode();
    t_prot();
    t_addr();
    t_hold();
    t_hold_reset();
    t_buf();
    t_lanes();
    close_out();
  end
endmodule // snf_front_end_tb_top

// ==== sim/snf_host_model.sv ====
// Host controller model driving clock, select and data lines
`timescale 1ns/1ns
module snf_host_model (
  input wire logic mclk_in,
  input wire logic [3:0] io_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_drv_out
);
  logic mode3_q;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_drv_out = 4'hf;
    mode3_q = 1'b0;
  end
  // ------
  // Half clock of five cycles, above the synchroniser delay
  // ------
  task automatic half();
    repeat (5) @(posedge mclk_in);
  endtask
  task automatic line(input int k, input logic v);
    io_drv_out[k] <= v;
  endtask
  task automatic sel(input logic m3);
    mode3_q = m3;
    io_drv_out[3] <= 1'b1;
    sclk_out <= m3;
    half();
    cs_n_out <= 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    cs_n_out <= 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      // Mode 0 already rests low; a second assignment would collide
      if (i > 0 || mode3_q) begin
        sclk_out <= 1'b0;
      end
      io_drv_out[0] <= d[7-i];
      half();
      r = {r[6:0], io_in[1]};
      sclk_out <= 1'b1;
      half();
    end
    if (!mode3_q) begin
      sclk_out <= 1'b0;
    end
  endtask
endmodule // snf_host_model
